// ==== inc/ocsi_consts.svh ====
`ifndef OCSI_CONSTS_SVH
`define OCSI_CONSTS_SVH
// ---------------------------------------------
// object indices and subindices
// ---------------------------------------------
`define OCSI_IDX_STATUS 16'h6000
`define OCSI_IDX_CTRL 16'h7000
`define OCSI_IDX_DIAG 16'h10f3
`define OCSI_IDX_TIME 16'h10f8
`define OCSI_IDX_DEVTYPE 16'h1000
`define OCSI_SUB_EN 8'h01
`define OCSI_SUB_TRIP 8'h02
`define OCSI_SUB_HWP 8'h05
`define OCSI_SUB_WARN 8'h08
`define OCSI_SUB_LOCK 8'h09
`define OCSI_SUB_DIAG 8'h0d
`define OCSI_SUB_INVAL 8'h0e
`define OCSI_SUB_CNT 8'h0f
`define OCSI_SUB_ERR 8'h13
`define OCSI_SUB_RST_ECHO 8'h14
`define OCSI_SUB_SW_ECHO 8'h15
`define OCSI_SUB_CLR_CMD 8'h01
`define OCSI_SUB_CONN_CMD 8'h02
`define OCSI_SUB_CAP 8'h01
`define OCSI_SUB_LATEST 8'h02
`define OCSI_SUB_ACKED 8'h03
`define OCSI_SUB_PEND 8'h04
`define OCSI_SUB_FLAGS 8'h05
`define OCSI_SUB_MSG0 8'h06
// ---------------------------------------------
// limits, profile and timing
// ---------------------------------------------
`define OCSI_DIAG_MAX 50
`define OCSI_COMM_PROFILE 16'h1389
`define OCSI_CLK_PERIOD_NS 40
`define OCSI_TICK_NS 64'h0000_0000_0000_0028
`endif

// ==== inc/ocsi_pkg.sv ====
package ocsi_pkg;
  // per-channel input status image
  typedef struct packed {
    logic switched_on;
    logic tripped;
    logic hw_protect;
    logic prewarn;
    logic restart_lock;
    logic new_diag;
    logic data_invalid;
    logic [1:0] fresh_cnt;
    logic hw_fault;
    logic reset_echo;
    logic switch_echo;
  } ocsi_status_type;
  // per-channel live state from the protection logic
  typedef struct packed {
    logic switched_on;
    logic tripped;
    logic hw_protect;
    logic restart_lock;
    logic hw_fault;
    logic fresh;
    logic valid;
    logic [15:0] current;
    logic [15:0] warn_level;
  } ocsi_live_type;
  // object access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] index;
    logic [7:0] sub;
    logic [2:0] word;
    logic [31:0] wdata;
  } ocsi_req_type;
  typedef enum logic [1:0] {
    OCSI_IDLE = 2'b01,
    OCSI_ANSWER = 2'b10
  } ocsi_state_type;
endpackage : ocsi_pkg

// ==== src/ocsi_image.sv ====
// Contract
// - two independent channels, status and control chosen by index 0 or 1.
// - the hardware protection flag is high only while the fault persists.
// - the prewarning flag is set when current is at or above the threshold.
// - the diagnosis flag rises whenever a new history entry is added.
// - the validity bit reads 0 for valid data and 1 for invalid data.
// - a 2-bit wrapping counter advances only on a fresh value, else holds.
// - the history reports its capacity and holds at most fifty messages.
// - a read-only pointer holds the subindex of the newest stored message.
// - the master writes the last confirmed subindex and the device keeps it.
// - the device type word is 5001 low and the module profile high.
`timescale 1ns/1ps
`default_nettype none
`include "ocsi_consts.svh"
module ocsi_image
  import ocsi_pkg::*;
#(
  parameter int DIAG_DEPTH = 16,
  parameter logic [15:0] MODULE_PROFILE = 16'h0abc // arbitrary value
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire ocsi_live_type live [2],
  input wire ocsi_req_type req,
  input wire logic diag_add,
  input wire logic diag_chan,
  input wire logic [159:0] diag_msg,
  output ocsi_status_type status [2],
  output logic [1:0] trip_clear_cmd,
  output logic [1:0] connect_cmd,
  output logic ack,
  output logic err,
  output logic [31:0] rd_data
);
  localparam int PW = $clog2(DIAG_DEPTH);
  localparam logic [7:0] DEPTH8 = 8'(DIAG_DEPTH);

  // every check below runs on mclk and rests while reset is low
  default clocking img_cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  // channel picked by the n digit of 60n0 / 70n0, or 2 (bit 1 set) on mismatch
  function automatic logic [1:0] chan_of(input logic [15:0] idx,
                                         input logic [15:0] base);
    logic [1:0] r;
    r = 2'b10;
    if ((idx & 16'hff0f) == base && idx[7:4] < 4'h2) begin
      r = {1'b0, idx[4]};
    end
    return r;
  endfunction : chan_of

  function automatic logic [1:0] inc2(input logic [1:0] v);
    return 2'(v + 2'h1);
  endfunction : inc2

  // ---------------------------------------------
  // channel status and control
  // ---------------------------------------------
  ocsi_status_type st_reg [2];
  ocsi_status_type st_next [2];
  logic [1:0] clr_reg, clr_next, conn_reg, conn_next;
  logic [1:0] ndiag_reg, ndiag_next;
  logic [7:0] latest_reg, latest_next, acked_reg, acked_next;
  logic [15:0] flags_reg, flags_next;
  logic [PW-1:0] wptr_reg, wptr_next;
  logic [63:0] time_reg, time_next;
  logic [1:0] wch;

  assign wch = chan_of(req.index, `OCSI_IDX_CTRL);

  // control bits come from master writes; the echo follows them
  always_comb begin
    clr_next = clr_reg;
    conn_next = conn_reg;
    if (req.wr && !wch[1]) begin
      if (req.sub == `OCSI_SUB_CLR_CMD) begin
        clr_next[wch[0]] = req.wdata[0];
      end
      if (req.sub == `OCSI_SUB_CONN_CMD) begin
        conn_next[wch[0]] = req.wdata[0];
      end
    end
  end

  // new-diag flag: set on add wins over the ack that clears it
  always_comb begin
    ndiag_next = ndiag_reg;
    if (req.wr && req.index == `OCSI_IDX_DIAG &&
        req.sub == `OCSI_SUB_ACKED && req.wdata[7:0] == latest_reg) begin
      ndiag_next = 2'b00;
    end
    if (diag_add) begin
      ndiag_next[diag_chan] = 1'b1;
    end
  end

  // image of each channel, one cycle behind the live state
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      st_next[c] = st_reg[c];
      st_next[c].switched_on = live[c].switched_on;
      st_next[c].tripped = live[c].tripped;
      st_next[c].hw_protect = live[c].hw_protect;
      st_next[c].prewarn = live[c].current >= live[c].warn_level;
      st_next[c].restart_lock = live[c].restart_lock;
      st_next[c].new_diag = ndiag_next[c];
      st_next[c].data_invalid = ~live[c].valid;
      st_next[c].hw_fault = live[c].hw_fault;
      st_next[c].reset_echo = clr_next[c];
      st_next[c].switch_echo = conn_next[c];
      if (live[c].fresh) begin
        st_next[c].fresh_cnt = inc2(st_reg[c].fresh_cnt);
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg[0] <= '0;
      st_reg[1] <= '0;
      clr_reg <= 2'h0;
      conn_reg <= 2'h0;
      ndiag_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      clr_reg <= clr_next;
      conn_reg <= conn_next;
      ndiag_reg <= ndiag_next;
    end
  end

  assign status = st_reg;
  assign trip_clear_cmd = clr_reg;
  assign connect_cmd = conn_reg;

  // ---------------------------------------------
  // diagnosis history and time stamp
  // ---------------------------------------------
  // ring store; the oldest entry is overwritten once full
  logic [159:0] msg_mem [DIAG_DEPTH];

  always_comb begin
    wptr_next = wptr_reg;
    latest_next = latest_reg;
    acked_next = acked_reg;
    flags_next = flags_reg;
    time_next = time_reg + `OCSI_TICK_NS;
    if (diag_add) begin
      latest_next = `OCSI_SUB_MSG0 + 8'(wptr_reg);
      wptr_next = (wptr_reg == PW'(DIAG_DEPTH - 1)) ? '0 :
                  PW'(wptr_reg + 1'b1);
    end
    if (req.wr && req.index == `OCSI_IDX_DIAG) begin
      if (req.sub == `OCSI_SUB_ACKED) begin
        acked_next = req.wdata[7:0];
      end
      if (req.sub == `OCSI_SUB_FLAGS) begin
        flags_next = req.wdata[15:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (diag_add) begin
      msg_mem[wptr_reg] <= diag_msg;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_reg <= '0;
      latest_reg <= 8'h00;
      acked_reg <= 8'h00;
      flags_reg <= 16'h0000;
      time_reg <= 64'h0;
    end else begin
      wptr_reg <= wptr_next;
      latest_reg <= latest_next;
      acked_reg <= acked_next;
      flags_reg <= flags_next;
      time_reg <= time_next;
    end
  end

  // ---------------------------------------------
  // object read port
  // ---------------------------------------------
  ocsi_state_type state_reg, state_next;
  logic err_next;
  logic [31:0] rd_next;
  logic [1:0] rch;
  logic [7:0] moff;
  logic [2:0] wsel;

  assign rch = chan_of(req.index, `OCSI_IDX_STATUS);
  assign moff = 8'(req.sub - `OCSI_SUB_MSG0);
  assign wsel = (req.word > 3'h4) ? 3'h4 : req.word;

  // answers every request one cycle later; reads of unknown objects flag err
  always_comb begin
    state_next = (req.rd || req.wr) ? OCSI_ANSWER : OCSI_IDLE;
    err_next = 1'b0;
    rd_next = 32'h0;
    if (req.rd) begin
      err_next = 1'b1;
      if (!rch[1]) begin
        err_next = 1'b0;
        unique case (req.sub)
          `OCSI_SUB_EN: rd_next[0] = st_reg[rch[0]].switched_on;
          `OCSI_SUB_TRIP: rd_next[0] = st_reg[rch[0]].tripped;
          `OCSI_SUB_HWP: rd_next[0] = st_reg[rch[0]].hw_protect;
          `OCSI_SUB_WARN: rd_next[0] = st_reg[rch[0]].prewarn;
          `OCSI_SUB_LOCK: rd_next[0] = st_reg[rch[0]].restart_lock;
          `OCSI_SUB_DIAG: rd_next[0] = st_reg[rch[0]].new_diag;
          `OCSI_SUB_INVAL: rd_next[0] = st_reg[rch[0]].data_invalid;
          `OCSI_SUB_CNT: rd_next[1:0] = st_reg[rch[0]].fresh_cnt;
          `OCSI_SUB_ERR: rd_next[0] = st_reg[rch[0]].hw_fault;
          `OCSI_SUB_RST_ECHO: rd_next[0] = st_reg[rch[0]].reset_echo;
          `OCSI_SUB_SW_ECHO: rd_next[0] = st_reg[rch[0]].switch_echo;
          default: err_next = 1'b1;
        endcase
      end else if (!wch[1]) begin
        err_next = 1'b0;
        unique case (req.sub)
          `OCSI_SUB_CLR_CMD: rd_next[0] = clr_reg[wch[0]];
          `OCSI_SUB_CONN_CMD: rd_next[0] = conn_reg[wch[0]];
          default: err_next = 1'b1;
        endcase
      end else if (req.index == `OCSI_IDX_DIAG) begin
        err_next = 1'b0;
        if (req.sub == `OCSI_SUB_CAP) begin
          rd_next[7:0] = DEPTH8;
        end else if (req.sub == `OCSI_SUB_LATEST) begin
          rd_next[7:0] = latest_reg;
        end else if (req.sub == `OCSI_SUB_ACKED) begin
          rd_next[7:0] = acked_reg;
        end else if (req.sub == `OCSI_SUB_PEND) begin
          rd_next[0] = latest_reg != acked_reg;
        end else if (req.sub == `OCSI_SUB_FLAGS) begin
          rd_next[15:0] = flags_reg;
        end else if (req.sub >= `OCSI_SUB_MSG0 && moff < DEPTH8) begin
          rd_next = msg_mem[moff[PW-1:0]][wsel*32 +: 32];
        end else begin
          err_next = 1'b1;
        end
      end else if (req.index == `OCSI_IDX_TIME) begin
        err_next = 1'b0;
        rd_next = req.word[0] ? time_reg[63:32] : time_reg[31:0];
      end else if (req.index == `OCSI_IDX_DEVTYPE) begin
        err_next = 1'b0;
        rd_next = {MODULE_PROFILE, `OCSI_COMM_PROFILE};
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= OCSI_IDLE;
      err <= 1'b0;
      rd_data <= 32'h0;
    end else begin
      state_reg <= state_next;
      err <= err_next;
      rd_data <= rd_next;
    end
  end

  // the one-hot answer bit is the ack flop, so no second copy is kept
  assign ack = state_reg[1];

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  chk_hwp_follow: assert property (
    ##1 status[0].hw_protect == $past(live[0].hw_protect))
    else $error("hw protect flag does not follow fault");
  chk_warn_level: assert property (
    live[0].current >= live[0].warn_level |=> status[0].prewarn)
    else $error("prewarn missing at or above threshold");
  chk_diag_raise: assert property (
    diag_add && !diag_chan |=> status[0].new_diag)
    else $error("diag flag not raised on new entry");
  chk_invalid_bit: assert property (
    !live[0].valid |=> status[0].data_invalid)
    else $error("invalid data not flagged");
  chk_cnt_step: assert property (
    live[0].fresh |=>
      status[0].fresh_cnt == 2'($past(status[0].fresh_cnt) + 2'h1))
    else $error("counter did not advance");
  chk_cnt_hold: assert property (
    !live[1].fresh |=> $stable(status[1].fresh_cnt))
    else $error("counter moved without fresh value");
  chk_cap_limit: assert property (
    DIAG_DEPTH <= `OCSI_DIAG_MAX)
    else $error("history capacity above fifty");
  chk_cap_report: assert property (
    req.rd && req.index == `OCSI_IDX_DIAG && req.sub == `OCSI_SUB_CAP
    |=> ack && !err && rd_data[7:0] == DEPTH8)
    else $error("capacity read does not report depth");
  chk_latest_ptr: assert property (
    diag_add |=> latest_reg >= `OCSI_SUB_MSG0 &&
      latest_reg < `OCSI_SUB_MSG0 + DEPTH8)
    else $error("newest pointer out of range");
  chk_ack_keep: assert property (
    req.wr && req.index == `OCSI_IDX_DIAG && req.sub == `OCSI_SUB_ACKED
    |=> acked_reg == $past(req.wdata[7:0]))
    else $error("acknowledged pointer not kept");
  chk_echo_cmd: assert property (
    ##1 status[0].switch_echo == connect_cmd[0] &&
      status[1].reset_echo == trip_clear_cmd[1])
    else $error("control echo mismatch");
endmodule : ocsi_image
`default_nettype wire

// ==== sim/ocsi_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocsi_master
  import ocsi_pkg::*;
(
  input wire logic mclk,
  input wire logic ack,
  input wire logic err,
  input wire logic [31:0] rd_data,
  output var ocsi_req_type req
);
  // ------------------------------------------
  // master side of the object access path
  // ------------------------------------------
  initial req = '0;

  // one-cycle strobe, then wait a bounded time for the answer
  task automatic access(
    input logic wr,
    input logic [15:0] idx,
    input logic [7:0] sub,
    input logic [2:0] word,
    input logic [31:0] wd,
    output logic [31:0] rd,
    output logic e
  );
    rd = 'x;
    e = 'x;
    @(negedge mclk);
    req <= '{rd: ~wr, wr: wr, index: idx, sub: sub, word: word,
             wdata: wd};
    @(negedge mclk);
    // released fields no longer show the old request
    req <= '{rd: 1'b0, wr: 1'b0, index: ~idx, sub: ~sub, word: ~word,
             wdata: ~wd};
    // ack stands only in the cycle after the taking edge: look at once
    for (int i = 0; i < 4; i++) begin
      if (ack === 1'b1) begin
        rd = rd_data;
        e = err;
        break;
      end
      @(negedge mclk);
    end
  endtask : access
endmodule : ocsi_master
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ocsi_consts.svh"
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tb_top
  import ocsi_pkg::*;
;
  // ------------------------------------------
  // clock, reset and design hookup
  // ------------------------------------------
  localparam int DEPTH = 4; // short ring keeps the wrap quick
  localparam logic [15:0] MOD_PROFILE = 16'h0abc; // arbitrary value
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  ocsi_live_type live [2] = '{default: '0};
  ocsi_req_type req;
  logic diag_add = 1'b0;
  logic diag_chan = 1'b0;
  logic [159:0] diag_msg = '0;
  ocsi_status_type status [2];
  logic [1:0] trip_clear_cmd;
  logic [1:0] connect_cmd;
  logic ack;
  logic err;
  logic [31:0] rd_data;
  ocsi_status_type s0;
  ocsi_status_type s1;
  int failures = 0;
  int checks = 0;

  always #20 mclk = ~mclk;

  // short names for the two status images
  assign s0 = status[0];
  assign s1 = status[1];

  ocsi_image #(.DIAG_DEPTH(DEPTH), .MODULE_PROFILE(MOD_PROFILE))
    dut (.mclk(mclk), .arst_n(arst_n),
    .live(live), .req(req), .diag_add(diag_add), .diag_chan(diag_chan),
    .diag_msg(diag_msg), .status(status), .trip_clear_cmd(trip_clear_cmd),
    .connect_cmd(connect_cmd), .ack(ack), .err(err), .rd_data(rd_data));

  ocsi_master u_mst (.mclk(mclk), .ack(ack), .err(err), .rd_data(rd_data),
    .req(req));

  // ------------------------------------------
  // shared helpers
  // ------------------------------------------
  task automatic end_sim;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic rd_obj(input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] exp, input logic exp_err);
    logic [31:0] d;
    logic e;
    u_mst.access(1'b0, idx, sub, 3'h0, 32'h0, d, e);
    `CHK(d, exp)
    `CHK(e, exp_err)
  endtask : rd_obj

  task automatic wr_obj(input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    u_mst.access(1'b1, idx, sub, 3'h0, wd, d, e);
    `CHK(e, 1'b0)
  endtask : wr_obj

  // status follows live with one cycle of latency
  task automatic settle;
    repeat (2) @(negedge mclk);
  endtask : settle

  task automatic add_msg(input logic c, input logic [159:0] m);
    @(negedge mclk);
    diag_chan = c;
    diag_msg = m;
    diag_add = 1'b1;
    @(negedge mclk);
    diag_add = 1'b0;
    settle();
  endtask : add_msg

  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  task automatic t_objects;
    rd_obj(`OCSI_IDX_DEVTYPE, 8'h00,
           {MOD_PROFILE, `OCSI_COMM_PROFILE}, 1'b0);
    rd_obj(16'h1234, 8'h00, 32'h0, 1'b1);
    wr_obj(`OCSI_IDX_CTRL | 16'h0010, `OCSI_SUB_CONN_CMD, 32'h1);
    `CHK({connect_cmd, s1.switch_echo, s0.switch_echo}, 4'ha)
    wr_obj(`OCSI_IDX_CTRL, `OCSI_SUB_CLR_CMD, 32'h1);
    `CHK({trip_clear_cmd, s0.reset_echo}, 3'h3)
    rd_obj(`OCSI_IDX_CTRL | 16'h0010, `OCSI_SUB_CONN_CMD, 32'h1, 1'b0);
    // read-only status is not writable from the master
    wr_obj(`OCSI_IDX_STATUS, `OCSI_SUB_EN, 32'h1);
    rd_obj(`OCSI_IDX_STATUS, `OCSI_SUB_EN, 32'h0, 1'b0);
    wr_obj(`OCSI_IDX_CTRL | 16'h0010, `OCSI_SUB_CONN_CMD, 32'h0);
    `CHK({connect_cmd[1], s1.switch_echo}, 2'h0)
  endtask : t_objects

  task automatic t_live;
    live[0] = '{switched_on: 1'b1, tripped: 1'b1, hw_protect: 1'b1,
      restart_lock: 1'b1, hw_fault: 1'b1, fresh: 1'b0, valid: 1'b0,
      current: 16'h0100, warn_level: 16'h0100};
    settle();
    // bits 11:8: switched on, tripped, hw protect, prewarn
    `CHK(s0[11:8], 4'hf)
    `CHK({s0.restart_lock, s0.data_invalid, s0.hw_fault}, 3'h7)
    `CHK(s1, '0)
    live[0].current = 16'h0101;
    settle();
    `CHK(status[0].prewarn, 1'b1)
    live[0].current = 16'h00ff;
    live[0].hw_protect = 1'b0;
    live[0].valid = 1'b1;
    settle();
    `CHK({s0.hw_protect, s0.prewarn, s0.data_invalid}, 3'h0)
  endtask : t_live

  task automatic t_counter;
    for (int i = 0; i < 5; i++) begin
      @(negedge mclk);
      live[0].fresh = 1'b1;
      @(negedge mclk);
      live[0].fresh = 1'b0;
    end
    settle();
    `CHK(status[0].fresh_cnt, 2'h1)
    repeat (6) @(negedge mclk);
    `CHK({s0.fresh_cnt, s1.fresh_cnt}, 4'h4)
  endtask : t_counter

  task automatic t_diag;
    rd_obj(`OCSI_IDX_DIAG, `OCSI_SUB_CAP, DEPTH, 1'b0);
    add_msg(1'b1, {128'h0, 32'hc0de_00a5});
    `CHK({status[1].new_diag, status[0].new_diag}, 2'h2)
    rd_obj(`OCSI_IDX_DIAG, `OCSI_SUB_LATEST, 32'h6, 1'b0);
    rd_obj(`OCSI_IDX_DIAG, `OCSI_SUB_PEND, 32'h1, 1'b0);
    rd_obj(`OCSI_IDX_DIAG, `OCSI_SUB_MSG0, 32'hc0de_00a5, 1'b0);
    wr_obj(`OCSI_IDX_DIAG, `OCSI_SUB_ACKED, 32'h6);
    rd_obj(`OCSI_IDX_DIAG, `OCSI_SUB_ACKED, 32'h6, 1'b0);
    rd_obj(`OCSI_IDX_DIAG, `OCSI_SUB_PEND, 32'h0, 1'b0);
    `CHK(status[1].new_diag, 1'b0)
    for (int i = 1; i < DEPTH; i++) begin
      add_msg(1'b0, 160'h1);
    end
    `CHK(status[0].new_diag, 1'b1)
    rd_obj(`OCSI_IDX_DIAG, `OCSI_SUB_LATEST, 5 + DEPTH, 1'b0);
    add_msg(1'b0, 160'h2);
    rd_obj(`OCSI_IDX_DIAG, `OCSI_SUB_LATEST, 32'h6, 1'b0);
    // the spare flags word is plain storage for the master
    wr_obj(`OCSI_IDX_DIAG, `OCSI_SUB_FLAGS, 32'h0000_a55a);
    rd_obj(`OCSI_IDX_DIAG, `OCSI_SUB_FLAGS, 32'h0000_a55a, 1'b0);
  endtask : t_diag

  // ------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------
  initial begin
    // idle channels: data valid and the threshold out of reach
    for (int c = 0; c < 2; c++) begin
      live[c].valid = 1'b1;
      live[c].warn_level = 16'hffff;
    end
    repeat (10) @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    `CHK({status[0], status[1], trip_clear_cmd, connect_cmd}, '0)
    t_objects();
    t_live();
    t_counter();
    t_diag();
    end_sim();
  end

  // whole run is about a hundred cycles; allow ample margin
  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
